// ===== bench/ffcc_host_model.sv
`timescale 1ns/1ps
module ffcc_host_model (
    input  wire i_clk,      // Clock
    input  wire i_srst,     // Reset
    input  wire i_slow,     // Stall mode
    input  wire i_nv_start, // Storage start
    output reg  o_rsp_rdy,  // Response accept
    output reg  o_nv_done   // Storage done
);
    reg [3:0] cnt;
    always @(posedge i_clk) begin
        o_rsp_rdy <= #1 i_srst ? 1'b0 : (i_slow ? ~o_rsp_rdy : 1'b1);
        o_nv_done <= #1 cnt == 4'h1;
        cnt <= #1 i_srst ? 4'h0 : (i_nv_start ? 4'h9 : cnt - {3'h0, |cnt});
    end
endmodule // ffcc_host_model

// ===== bench/ffcc_monitor.sv
`timescale 1ns/1ps
`include "ffcc_defs.vh"
module ffcc_monitor #(
    parameter W    = 10,
    parameter NPIX = 16,
    parameter AW   = 4
) (
    input wire          i_clk,      // Clock
    input wire          i_srst,     // Reset
    input wire          i_cmd_vld,  // Strobe
    input wire [2:0]    i_cmd,      // Code
    input wire          i_has_val,  // Value flag
    input wire [W-1:0]  i_val,      // Value
    input wire          i_mode10,   // Mode
    input wire          i_rsp_rdy,  // Accept
    input wire          o_busy,     // Busy
    input wire [W-1:0]  o_aoff,     // Offset
    input wire [W-1:0]  o_again,    // Gain
    input wire          o_nv_start, // Store
    input wire          o_rsp_vld,  // Valid
    input wire [3:0]    o_rsp_code, // Code
    input wire [AW-1:0] o_rsp_pix,  // Pixel
    input wire [W-1:0]  o_rsp_data  // Data
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    wire take = i_cmd_vld && !o_busy;
    wire dark = take && i_cmd == `FFCC_CMD_DARK;
    wire out8 = i_val < `FFCC_DOFF_MIN8 || i_val > `FFCC_DOFF_MAX8;
    wire out10 = i_val < `FFCC_DOFF_MIN10 || i_val > `FFCC_DOFF_MAX10;
    wire bad = dark && i_has_val && (i_mode10 ? out10 : out8);
    reg [W-1:0]  v;
    reg [AW-1:0] hp;
    always @(posedge i_clk) begin
        if (take) v <= i_val;
        if (o_rsp_vld && i_rsp_rdy) hp <= o_rsp_pix;
    end
    a_rsp_fields_hold: assert property (o_rsp_vld && !i_rsp_rdy |=> o_rsp_vld &&
        $stable({o_rsp_code, o_rsp_pix, o_rsp_data})) else $error("response moved early");
    a_save_starts_nv: assert property (take && i_cmd == `FFCC_CMD_SAVE |-> ##[1:3] o_nv_start)
        else $error("no storage start");
    a_nv_one_cycle: assert property (o_nv_start |=> !o_nv_start) else $error("long start");
    a_bad_val_err: assert property (bad |-> ##[1:2] o_rsp_vld &&
        o_rsp_code == `FFCC_RSP_ERR) else $error("no error code");
    a_bad_keeps_aoff: assert property (bad |=> $stable(o_aoff) [*3])
        else $error("offset changed");
    a_dark_loads_aoff: assert property (dark && i_has_val && !bad |-> ##[1:3] o_aoff == v)
        else $error("offset not loaded");
    a_dark_keeps_aoff: assert property (dark && !i_has_val |=> $stable(o_aoff) [*4])
        else $error("offset moved");
    a_white_keeps_gain: assert property (take && i_cmd == `FFCC_CMD_WHITE && !i_has_val
        |=> $stable(o_again) [*4]) else $error("gain moved");
    a_query_settings: assert property (take && i_cmd == `FFCC_CMD_QUERY |-> ##[1:2]
        o_rsp_vld && o_rsp_code == `FFCC_RSP_SET) else $error("no settings");
    a_dump_pairs: assert property (o_rsp_vld && i_rsp_rdy && o_rsp_code == `FFCC_RSP_FPN
        |-> ##[1:3] o_rsp_vld && o_rsp_code == `FFCC_RSP_PRNU && o_rsp_pix == hp)
        else $error("gain not paired");
    c_bad: cover property (bad);
    c_store: cover property (o_nv_start);
    c_var: cover property (o_rsp_vld && o_rsp_code == `FFCC_RSP_WARN_VAR);
endmodule // ffcc_monitor

// ===== bench/test_flat_field_calibration_control.sv
`timescale 1ns/1ps
`include "ffcc_defs.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module test_flat_field_calibration_control;
    reg        i_clk = 0, i_srst = 1, i_cmd_vld = 0, i_has_val = 0, i_mode10 = 0, slow = 0;
    reg  [2:0] i_cmd = 0;
    reg  [9:0] i_val = 0, lvl = 20, bad_val = 20;
    reg  [3:0] i_dump_lo = 0, i_dump_hi = 15, pcnt = 0, bad_pix = 5;
    wire       i_rsp_rdy, i_nv_done, o_busy, o_nv_start, o_rsp_vld, o_pix_vld;
    wire [9:0] o_aoff, o_again, o_rsp_data, o_pix;
    wire [3:0] o_rsp_code, o_rsp_pix;
    wire       i_line_vld = 1'b1;
    wire [9:0] i_line_pix = (pcnt == bad_pix) ? bad_val : lvl;
    int        n_mismatch = 0, n_tests = 0, nvc = 0;
    reg  [3:0] rc[$], rp[$];
    ffcc_ctrl u_dut (
        .i_clk      (i_clk),
        .i_srst     (i_srst),
        .i_cmd_vld  (i_cmd_vld),
        .i_cmd      (i_cmd),
        .i_has_val  (i_has_val),
        .i_val      (i_val),
        .i_dump_lo  (i_dump_lo),
        .i_dump_hi  (i_dump_hi),
        .i_mode10   (i_mode10),
        .i_line_vld (i_line_vld),
        .i_line_pix (i_line_pix),
        .i_rsp_rdy  (i_rsp_rdy),
        .i_nv_done  (i_nv_done),
        .o_busy     (o_busy),
        .o_aoff     (o_aoff),
        .o_again    (o_again),
        .o_nv_start (o_nv_start),
        .o_rsp_vld  (o_rsp_vld),
        .o_rsp_code (o_rsp_code),
        .o_rsp_pix  (o_rsp_pix),
        .o_rsp_data (o_rsp_data),
        .o_pix_vld  (o_pix_vld),
        .o_pix      (o_pix)
    );
    ffcc_host_model u_host (.i_clk(i_clk), .i_srst(i_srst), .i_slow(slow),
        .i_nv_start(o_nv_start), .o_rsp_rdy(i_rsp_rdy), .o_nv_done(i_nv_done));
    initial forever #2.5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        pcnt <= #1 pcnt + 4'h1;
        if (o_nv_start) nvc++;
        if (o_rsp_vld && i_rsp_rdy) begin
            rc.push_back(o_rsp_code);
            rp.push_back(o_rsp_pix);
        end
    end
    task end_of_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    function automatic bit has(input [3:0] c);
        has = 0;
        foreach (rc[i]) if (rc[i] === c) has = 1;
    endfunction
    task automatic cmd(input [2:0] c, input hv, input [9:0] v);
        int k;
        rc.delete();
        rp.delete();
        @(posedge i_clk) #1;
        {i_cmd, i_has_val, i_val, i_cmd_vld} = {c, hv, v, 1'b1};
        @(posedge i_clk) #1 i_cmd_vld = 0;
        for (k = 0; k < 2000 && (o_busy !== 1'b0 || o_rsp_vld !== 1'b0 || k < 2); k++)
            @(posedge i_clk) #1;
        if (k == 2000) begin n_mismatch++; end_of_test(); end
    endtask
    task automatic t_dark;
        reg [9:0] dv[8] = '{0, 1, 100, 101, 3, 4, 400, 401};
        reg [9:0] e;
        bit ok;
        `CHK(lvl > 0 && lvl < 128, 1'b1)
        for (int i = 0; i < 8; i++) begin
            i_mode10 = i > 3;
            e = o_aoff;
            ok = i % 4 == 1 || i % 4 == 2;
            cmd(1, 1, dv[i]);
            `CHK(rc[$], ok ? 4'h0 : 4'h1)
            `CHK(o_aoff, ok ? dv[i] : e)
        end
        i_mode10 = 0;
        e = o_aoff;
        cmd(1, 0, 0);
        `CHK(o_aoff, e)
        `CHK(rc[$], 4'h0)
    endtask
    task automatic t_white(input hv, input [9:0] v, bv, input [3:0] fin, w);
        reg [9:0] g;
        g = o_again;
        lvl = 200;
        bad_val = bv;
        `CHK(lvl >= 128 && lvl <= 254, 1'b1)
        cmd(2, hv, v);
        `CHK(o_again, hv ? v : g)
        `CHK(rc[$], fin)
        `CHK(has(w), 1'b1)
    endtask
    task automatic t_dump;
        {i_dump_lo, i_dump_hi, slow} = {4'h2, 4'h3, 1'b1};
        cmd(4, 0, 0);
        `CHK(rc.size(), 4)
        for (int i = 0; i < 4; i++) begin
            `CHK(rc[i], i % 2 ? 4'h6 : 4'h5)
            `CHK(rp[i], 4'(2 + i / 2))
        end
        slow = 0;
    endtask
    initial begin
        repeat (10) @(posedge i_clk);
        #1 i_srst = 0;
        `CHK({o_busy, o_rsp_vld, o_aoff, o_again}, 22'h0)
        t_dark(); // Offsets before gains
        t_white(1, 251, 200, 0, 0);
        // Flat white, unit gain: corrected pixel is white minus dark level
        @(posedge i_clk) #1;
        `CHK({o_pix_vld, o_pix}, {1'b1, 10'h0b4})
        t_white(0, 0, 64, 0, 3);
        t_white(0, 0, 255, 0, 2);
        t_white(0, 0, 0, 1, 4);
        t_dump();
        cmd(3, 0, 0);
        `CHK(nvc, 1)
        `CHK(rc[$], 4'h0)
        cmd(5, 0, 0);
        `CHK(rc[0], 4'h7)
        end_of_test();
    end
endmodule // test_flat_field_calibration_control
bind ffcc_ctrl ffcc_monitor #(.W(W), .NPIX(NPIX), .AW(AW)) u_mon (
    .i_clk      (i_clk),
    .i_srst     (i_srst),
    .i_cmd_vld  (i_cmd_vld),
    .i_cmd      (i_cmd),
    .i_has_val  (i_has_val),
    .i_val      (i_val),
    .i_mode10   (i_mode10),
    .i_rsp_rdy  (i_rsp_rdy),
    .o_busy     (o_busy),
    .o_aoff     (o_aoff),
    .o_again    (o_again),
    .o_nv_start (o_nv_start),
    .o_rsp_vld  (o_rsp_vld),
    .o_rsp_code (o_rsp_code),
    .o_rsp_pix  (o_rsp_pix),
    .o_rsp_data (o_rsp_data)
);

// ===== design/ffcc_corr.v
`timescale 1ns/1ps
`include "ffcc_defs.vh"
// Two-point pixel correction, one pixel per clock
module ffcc_corr #(
    parameter W = 10
) (
    input  wire         i_clk,   // Clock
    input  wire         i_srst,  // Sync reset
    input  wire         i_vld,   // Pixel valid
    input  wire [W-1:0] i_pix,   // Raw pixel
    input  wire [W-1:0] i_fpn,   // Pixel offset coefficient
    input  wire [W-1:0] i_doff,  // Global digital offset
    input  wire [8:0]   i_prnu,  // Gain coefficient, 1+g/512
    output reg          o_vld,   // Corrected valid
    output reg  [W-1:0] o_pix    // Corrected pixel
);
    wire [W+1:0]  diff = {2'b00, i_pix} - {2'b00, i_fpn} - {2'b00, i_doff};
    wire [W:0]    base = diff[W+1] ? {(W+1){1'b0}} : diff[W:0];
    wire [W+10:0] prod = {base, 10'h000} + ({10'h000, base} * {1'b0, i_prnu, 1'b0});
    wire [W:0]    res  = prod[W+10:10];
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_vld <= 1'b0;
            o_pix <= {W{1'b0}};
        end else begin
            o_vld <= i_vld;
            o_pix <= res[W] ? {W{1'b1}} : res[W-1:0];
        end
    end
endmodule // ffcc_corr

// ===== design/ffcc_ctrl.v
`timescale 1ns/1ps
`include "ffcc_defs.vh"
// Calibration command controller with coefficient store
module ffcc_ctrl #(
    parameter W    = 10,
    parameter NPIX = 16,
    parameter AW   = 4
) (
    input  wire         i_clk,        // Clock
    input  wire         i_srst,       // Sync reset
    input  wire         i_cmd_vld,    // Decoded command strobe
    input  wire [2:0]   i_cmd,        // Command code
    input  wire         i_has_val,    // Optional value present
    input  wire [W-1:0] i_val,        // Optional value
    input  wire [AW-1:0] i_dump_lo,   // Dump first pixel
    input  wire [AW-1:0] i_dump_hi,   // Dump last pixel
    input  wire         i_mode10,     // 10-bit data mode
    input  wire         i_line_vld,   // Averaged line pixel valid
    input  wire [W-1:0] i_line_pix,   // Averaged pixel value
    input  wire         i_rsp_rdy,    // Host link ready
    input  wire         i_nv_done,    // Storage write finished
    output wire         o_busy,       // Command in progress
    output reg  [W-1:0] o_aoff,       // Analog offset setting
    output reg  [W-1:0] o_again,      // Analog gain target
    output reg          o_nv_start,   // Storage write pulse
    output wire         o_rsp_vld,    // Response valid
    output reg  [3:0]   o_rsp_code,   // Response code
    output reg  [AW-1:0] o_rsp_pix,   // Response pixel number
    output reg  [W-1:0] o_rsp_data,   // Response data
    output wire         o_pix_vld,    // Corrected pixel valid
    output wire [W-1:0] o_pix         // Corrected pixel
);
    localparam S_IDLE = 3'h0;
    localparam S_DARK = 3'h1;
    localparam S_WHT  = 3'h2;
    localparam S_REP  = 3'h3;
    localparam S_SAVE = 3'h4;
    localparam S_DUMP = 3'h5;
    localparam S_RSP  = 3'h6;

    reg [W-1:0]  fpn  [0:NPIX-1];
    reg [8:0]    prnu [0:NPIX-1];
    reg [2:0]    state;
    reg [AW-1:0] idx;
    reg [AW-1:0] last;
    reg          half;
    reg [W-1:0]  doff;
    reg [W-1:0]  dmin;
    reg [W-1:0]  wmax;
    reg [W-1:0]  wmin;
    reg          w_lvl;
    reg          w_fov;
    reg [1:0]    rep;
    reg          rsp_on;
    reg [AW-1:0] cidx;

    function in_rng;
        input [W-1:0] v;
        input [W-1:0] lo;
        input [W-1:0] hi;
        in_rng = (v >= lo) && (v <= hi);
    endfunction

    wire val_ok = i_mode10 ?
        (i_cmd == `FFCC_CMD_DARK ? in_rng(i_val, `FFCC_DOFF_MIN10, `FFCC_DOFF_MAX10)
                                 : in_rng(i_val, `FFCC_WHT_MIN10, `FFCC_WHT_MAX10)) :
        (i_cmd == `FFCC_CMD_DARK ? in_rng(i_val, `FFCC_DOFF_MIN8, `FFCC_DOFF_MAX8)
                                 : in_rng(i_val, `FFCC_WHT_MIN8, `FFCC_WHT_MAX8));
    // Pixel window given in 8-bit units, scaled by four in 10-bit mode
    localparam [W-1:0] PIX_LO8 = `FFCC_PIX_LO;
    localparam [W-1:0] PIX_HI8 = `FFCC_PIX_HI;
    wire [W-1:0] px_lo = i_mode10 ? {PIX_LO8[W-3:0], 2'b00} : PIX_LO8;
    wire [W-1:0] px_hi = i_mode10 ? {PIX_HI8[W-3:0], 2'b00} : PIX_HI8;
    wire [W-1:0] dk    = i_line_pix - doff;
    wire [W+8:0] ratio = (wmax > dk && dk != {W{1'b0}}) ?
                         ({wmax, 9'h000} / {9'h000, dk}) : {(W+9){1'b0}};
    wire         hand  = rsp_on && i_rsp_rdy;

    assign o_busy    = (state != S_IDLE);
    assign o_rsp_vld = rsp_on;

    always @(posedge i_clk) begin
        if (i_srst) begin
            state <= S_IDLE;
            idx <= {AW{1'b0}};
            last <= {AW{1'b0}};
            half <= 1'b0;
            doff <= {W{1'b0}};
            dmin <= {W{1'b1}};
            wmax <= {W{1'b0}};
            wmin <= {W{1'b1}};
            w_lvl <= 1'b0;
            w_fov <= 1'b0;
            rep <= 2'h0;
            rsp_on <= 1'b0;
            o_aoff <= {W{1'b0}};
            o_again <= {W{1'b0}};
            o_nv_start <= 1'b0;
            o_rsp_code <= 4'h0;
            o_rsp_pix <= {AW{1'b0}};
            o_rsp_data <= {W{1'b0}};
        end else begin
            o_nv_start <= 1'b0;
            if (hand)
                rsp_on <= 1'b0;
            case (state)
            S_IDLE: begin
                idx <= {AW{1'b0}};
                if (i_cmd_vld) begin
                    if ((i_cmd == `FFCC_CMD_DARK || i_cmd == `FFCC_CMD_WHITE)
                        && i_has_val && !val_ok) begin
                        o_rsp_code <= `FFCC_RSP_ERR;
                        rsp_on <= 1'b1;
                        state <= S_RSP;
                    end else case (i_cmd)
                    `FFCC_CMD_DARK: begin
                        if (i_has_val)
                            o_aoff <= i_val;
                        dmin <= {W{1'b1}};
                        state <= S_DARK;
                    end
                    `FFCC_CMD_WHITE: begin
                        if (i_has_val)
                            o_again <= i_val;
                        wmax <= {W{1'b0}};
                        wmin <= {W{1'b1}};
                        w_lvl <= 1'b0;
                        w_fov <= 1'b0;
                        half <= 1'b0;
                        state <= S_WHT;
                    end
                    `FFCC_CMD_SAVE: begin
                        o_nv_start <= 1'b1;
                        state <= S_SAVE;
                    end
                    `FFCC_CMD_DUMP: begin
                        idx <= i_dump_lo;
                        last <= i_dump_hi;
                        half <= 1'b0;
                        state <= S_DUMP;
                    end
                    `FFCC_CMD_QUERY: begin
                        o_rsp_code <= `FFCC_RSP_SET;
                        o_rsp_pix <= {AW{1'b0}};
                        o_rsp_data <= doff;
                        rsp_on <= 1'b1;
                        state <= S_RSP;
                    end
                    default: state <= S_IDLE;
                    endcase
                end
            end
            S_DARK: if (i_line_vld) begin
                fpn[idx] <= i_line_pix;
                if (i_line_pix < dmin)
                    dmin <= i_line_pix;
                if (idx == NPIX - 1) begin
                    doff <= (i_line_pix < dmin) ? i_line_pix : dmin;
                    o_rsp_code <= `FFCC_RSP_OK;
                    rsp_on <= 1'b1;
                    state <= S_RSP;
                end
                idx <= idx + 1'b1;
            end
            S_WHT: if (i_line_vld) begin
                if (!in_rng(i_line_pix, px_lo, px_hi))
                    w_lvl <= 1'b1;
                if (i_line_pix <= doff)
                    w_fov <= 1'b1;
                if (!half) begin
                    if (dk > wmax)
                        wmax <= dk;
                    if (dk < wmin)
                        wmin <= dk;
                end else begin
                    prnu[idx] <= (ratio[W+8:9] >= 2) ? 9'h1ff :
                                 (ratio[W+8:9] == 0 ? 9'h000 : ratio[8:0]);
                end
                if (idx == NPIX - 1) begin
                    half <= 1'b1;
                    if (half) begin
                        rep <= 2'h0;
                        state <= S_REP;
                    end
                end
                idx <= idx + 1'b1;
            end
            S_REP: if (!rsp_on || hand) begin
                rsp_on <= 1'b1;
                rep <= rep + 2'h1;
                if (rep == 2'h0 && w_lvl)
                    o_rsp_code <= `FFCC_RSP_WARN_LVL;
                else if (rep <= 2'h1 && {wmin, 2'b00} < wmax) begin
                    o_rsp_code <= `FFCC_RSP_WARN_VAR;
                    rep <= 2'h2;
                end else if (rep <= 2'h2 && w_fov) begin
                    o_rsp_code <= `FFCC_RSP_WARN_FOV;
                    rep <= 2'h3;
                end else begin
                    o_rsp_code <= (w_fov) ? `FFCC_RSP_ERR : `FFCC_RSP_OK;
                    state <= S_RSP;
                end
            end
            S_SAVE: if (i_nv_done) begin
                o_rsp_code <= `FFCC_RSP_OK;
                rsp_on <= 1'b1;
                state <= S_RSP;
            end
            S_DUMP: if (!rsp_on || hand) begin
                rsp_on <= 1'b1;
                o_rsp_pix <= idx;
                o_rsp_code <= half ? `FFCC_RSP_PRNU : `FFCC_RSP_FPN;
                o_rsp_data <= half ? {{(W-9){1'b0}}, prnu[idx]} : fpn[idx];
                half <= ~half;
                if (half) begin
                    idx <= idx + 1'b1;
                    if (idx == last)
                        state <= S_RSP;
                end
            end
            S_RSP: if (hand || !rsp_on)
                state <= S_IDLE;
            default: state <= S_IDLE;
            endcase
        end
    end

    always @(posedge i_clk) begin
        if (i_srst)
            cidx <= {AW{1'b0}};
        else if (i_line_vld && !o_busy)
            cidx <= (cidx == NPIX - 1) ? {AW{1'b0}} : cidx + 1'b1;
    end

    ffcc_corr #(
        .W(W)
    ) u_corr (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .i_vld  (i_line_vld && !o_busy),
        .i_pix  (i_line_pix),
        .i_fpn  (fpn[cidx] - doff),
        .i_doff (doff),
        .i_prnu (prnu[cidx]),
        .o_vld  (o_pix_vld),
        .o_pix  (o_pix)
    );
endmodule // ffcc_ctrl

// ===== design/ffcc_defs.vh
`ifndef FFCC_DEFS_VH
`define FFCC_DEFS_VH
`define FFCC_CMD_DARK      3'h1
`define FFCC_CMD_WHITE     3'h2
`define FFCC_CMD_SAVE      3'h3
`define FFCC_CMD_DUMP      3'h4
`define FFCC_CMD_QUERY     3'h5
`define FFCC_RSP_OK        4'h0
`define FFCC_RSP_ERR       4'h1
`define FFCC_RSP_WARN_LVL  4'h2
`define FFCC_RSP_WARN_VAR  4'h3
`define FFCC_RSP_WARN_FOV  4'h4
`define FFCC_RSP_FPN       4'h5
`define FFCC_RSP_PRNU      4'h6
`define FFCC_RSP_SET       4'h7
`define FFCC_DOFF_MIN8     10'h001
`define FFCC_DOFF_MAX8     10'h064
`define FFCC_DOFF_MIN10    10'h004
`define FFCC_DOFF_MAX10    10'h190
`define FFCC_WHT_MIN8      10'h040
`define FFCC_WHT_MAX8      10'h0fb
`define FFCC_WHT_MIN10     10'h100
`define FFCC_WHT_MAX10     10'h3ef
`define FFCC_PIX_LO        10'h040
`define FFCC_PIX_HI        10'h0fe
`define FFCC_FPN_MAX       10'h07f
`endif
